// >>> rtl/acpp_pkg.sv
// Package of widths, field layouts and the error-flag carrier struct for channel parity protection.
package acpp_pkg;

  // Default interface widths.
  localparam int ACPP_ID_W_WIDTH    = 8;
  localparam int ACPP_ID_R_WIDTH    = 8;
  localparam int ACPP_ADDR_WIDTH    = 48;
  localparam int ACPP_DATA_WIDTH    = 128;
  localparam int ACPP_USER_REQ_W    = 16;
  localparam int ACPP_USER_DATA_W   = 16;
  localparam int ACPP_USER_RESP_W   = 16;
  localparam int ACPP_SID_WIDTH     = 32;
  localparam int ACPP_SSID_WIDTH    = 20;
  localparam int ACPP_LOOP_W_WIDTH  = 8;

  // Fixed field widths of single-bit check groups, then check group sizes and bits covered per check.
  localparam int ACPP_LEN_W         = 8;
  localparam int ACPP_CTL0_W        = 9;
  localparam int ACPP_CTL1_W        = 12;
  localparam int ACPP_CTL2_W        = 9;
  localparam int ACPP_CTL3_W        = 10;
  localparam int ACPP_NSAID_W       = 4;
  localparam int ACPP_STASHNID_W    = 12;
  localparam int ACPP_STASHLPID_W   = 6;
  localparam int ACPP_MMU_W         = 4;
  localparam int ACPP_MPAM_W        = 11;
  localparam int ACPP_BRESP_W       = 7;
  localparam int ACPP_GROUP_BITS    = 8;
  localparam int ACPP_TAG_GROUP     = 4;
  localparam int ACPP_STRB_PER_CHK  = 64;
  localparam int ACPP_TAG_PER_CHK   = 128;
  localparam int ACPP_PSN_PER_CHK   = 512;
  localparam int ACPP_PSN_GRANULE   = 64;

  // Error flag positions, one per channel.
  localparam int ACPP_ERR_AW        = 0;
  localparam int ACPP_ERR_W         = 1;
  localparam int ACPP_ERR_B         = 2;
  localparam int ACPP_ERR_AR        = 3;
  localparam int ACPP_ERR_N         = 4;

  // Error flags as a carrier.
  typedef struct packed {
    logic ar;
    logic b;
    logic w;
    logic aw;
  } acpp_err_s;

  // Number of bytes needed to hold w bits.
  function automatic int acpp_bytes(input int w);
    return (w + ACPP_GROUP_BITS - 1) / ACPP_GROUP_BITS;
  endfunction

endpackage

// >>> rtl/acpp_subordinate.sv
// Subordinate-side parity generator and checker for AW, W, B and AR channels.
`timescale 1ns/1ps
`default_nettype none

module acpp_subordinate
  import acpp_pkg::*;
#(
  parameter int ID_W_WIDTH  = ACPP_ID_W_WIDTH,
  parameter int ID_R_WIDTH  = ACPP_ID_R_WIDTH,
  parameter int ADDR_WIDTH  = ACPP_ADDR_WIDTH,
  parameter int DATA_WIDTH  = ACPP_DATA_WIDTH,
  parameter int USER_REQ_W  = ACPP_USER_REQ_W,
  parameter int USER_DATA_W = ACPP_USER_DATA_W,
  parameter int USER_RESP_W = ACPP_USER_RESP_W,
  parameter int SID_WIDTH   = ACPP_SID_WIDTH,
  parameter int SSID_WIDTH  = ACPP_SSID_WIDTH,
  parameter int LOOP_WIDTH  = ACPP_LOOP_W_WIDTH,
  localparam int IDW_C  = acpp_bytes(ID_W_WIDTH + 1),
  localparam int IDR_C  = acpp_bytes(ID_R_WIDTH + 1),
  localparam int ADR_C  = acpp_bytes(ADDR_WIDTH),
  localparam int DAT_C  = DATA_WIDTH / ACPP_GROUP_BITS,
  localparam int STB_C  = (DATA_WIDTH + ACPP_STRB_PER_CHK - 1) / ACPP_STRB_PER_CHK,
  localparam int TAG_C  = (DATA_WIDTH + ACPP_TAG_PER_CHK - 1) / ACPP_TAG_PER_CHK,
  localparam int PSN_C  = (DATA_WIDTH + ACPP_PSN_PER_CHK - 1) / ACPP_PSN_PER_CHK,
  localparam int PSN_W  = (DATA_WIDTH + ACPP_PSN_GRANULE - 1) / ACPP_PSN_GRANULE,
  localparam int TAG_W  = TAG_C * ACPP_TAG_GROUP,
  localparam int UREQ_C = acpp_bytes(USER_REQ_W),
  localparam int UDAT_C = acpp_bytes(USER_DATA_W),
  localparam int URSP_C = acpp_bytes(USER_RESP_W),
  localparam int SID_C  = acpp_bytes(SID_WIDTH),
  localparam int SSID_C = acpp_bytes(SSID_WIDTH)
) (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // Write-address channel from manager.
  input  wire logic                          aw_valid,
  input  wire logic                          aw_valid_chk,
  output logic                               aw_ready_chk,
  input  wire logic                          aw_ready,
  input  wire logic [ID_W_WIDTH:0]           aw_id,
  input  wire logic [IDW_C-1:0]              aw_id_chk,
  input  wire logic [ADDR_WIDTH-1:0]         aw_addr,
  input  wire logic [ADR_C-1:0]              aw_addr_chk,
  input  wire logic [ACPP_LEN_W-1:0]         aw_len,
  input  wire logic                          aw_len_chk,
  input  wire logic [ACPP_CTL0_W-1:0]        aw_ctl0,
  input  wire logic                          aw_ctl0_chk,
  input  wire logic [ACPP_CTL1_W-1:0]        aw_ctl1,
  input  wire logic                          aw_ctl1_chk,
  input  wire logic [ACPP_CTL2_W-1:0]        aw_ctl2,
  input  wire logic                          aw_ctl2_chk,
  input  wire logic [ACPP_CTL3_W-1:0]        aw_ctl3,
  input  wire logic                          aw_ctl3_chk,
  input  wire logic [ACPP_NSAID_W-1:0]       aw_nsaid,
  input  wire logic                          aw_nsaid_chk,
  input  wire logic [ACPP_STASHNID_W-1:0]    aw_stash_nid,
  input  wire logic                          aw_stash_nid_chk,
  input  wire logic [ACPP_STASHLPID_W-1:0]   aw_stash_lpid,
  input  wire logic                          aw_stash_lpid_chk,
  input  wire logic                          aw_trace,
  input  wire logic                          aw_trace_chk,
  input  wire logic [LOOP_WIDTH-1:0]         aw_loop,
  input  wire logic                          aw_loop_chk,
  input  wire logic [ACPP_MMU_W-1:0]         aw_mmu,
  input  wire logic                          aw_mmu_chk,
  input  wire logic [ACPP_MPAM_W-1:0]        aw_mpam,
  input  wire logic                          aw_mpam_chk,
  input  wire logic [USER_REQ_W-1:0]         aw_user,
  input  wire logic [UREQ_C-1:0]             aw_user_chk,
  input  wire logic [SID_WIDTH-1:0]          aw_sid,
  input  wire logic [SID_C-1:0]              aw_sid_chk,
  input  wire logic [SSID_WIDTH-1:0]         aw_ssid,
  input  wire logic [SSID_C-1:0]             aw_ssid_chk,
  // Write-data channel from manager.
  input  wire logic                          w_valid,
  input  wire logic                          w_valid_chk,
  input  wire logic                          w_ready,
  output logic                               w_ready_chk,
  input  wire logic [DATA_WIDTH-1:0]         w_data,
  input  wire logic [DAT_C-1:0]              w_data_chk,
  input  wire logic [DATA_WIDTH/8-1:0]       w_strb,
  input  wire logic [STB_C-1:0]              w_strb_chk,
  input  wire logic [TAG_W-1:0]              w_tag,
  input  wire logic [TAG_C-1:0]              w_tag_update,
  input  wire logic [TAG_C-1:0]              w_tag_chk,
  input  wire logic [USER_DATA_W-1:0]        w_user,
  input  wire logic [UDAT_C-1:0]             w_user_chk,
  input  wire logic [PSN_W-1:0]              w_poison,
  input  wire logic [PSN_C-1:0]              w_poison_chk,
  input  wire logic                          w_last,
  input  wire logic                          w_last_chk,
  input  wire logic                          w_trace,
  input  wire logic                          w_trace_chk,
  // Write-response channel toward manager.
  input  wire logic                          b_valid,
  output logic                               b_valid_chk,
  input  wire logic                          b_ready,
  input  wire logic                          b_ready_chk,
  input  wire logic [ID_W_WIDTH:0]           b_id,
  output logic [IDW_C-1:0]                   b_id_chk,
  input  wire logic [ACPP_BRESP_W-1:0]       b_resp,
  output logic                               b_resp_chk,
  input  wire logic                          b_trace,
  output logic                               b_trace_chk,
  input  wire logic [LOOP_WIDTH-1:0]         b_loop,
  output logic                               b_loop_chk,
  input  wire logic [USER_RESP_W-1:0]        b_user,
  output logic [URSP_C-1:0]                  b_user_chk,
  // Read-address channel from manager.
  input  wire logic                          ar_valid,
  input  wire logic                          ar_valid_chk,
  input  wire logic                          ar_ready,
  output logic                               ar_ready_chk,
  input  wire logic [ID_R_WIDTH:0]           ar_id,
  input  wire logic [IDR_C-1:0]              ar_id_chk,
  input  wire logic [ADDR_WIDTH-1:0]         ar_addr,
  input  wire logic [ADR_C-1:0]              ar_addr_chk,
  input  wire logic [ACPP_LEN_W-1:0]         ar_len,
  input  wire logic                          ar_len_chk,
  input  wire logic [ACPP_CTL0_W-1:0]        ar_ctl0,
  input  wire logic                          ar_ctl0_chk,
  input  wire logic [ACPP_CTL1_W-1:0]        ar_ctl1,
  input  wire logic                          ar_ctl1_chk,
  // Error reporting.
  input  wire logic                          err_clear,
  output acpp_err_s                          err_flags,
  output logic                               err_any
);

  // Parameters the byte-group logic cannot serve are refused.
  // The parity helper spans 1024 payload bits, so no group may need more than 128 checks.
  if (DATA_WIDTH < 32 || DATA_WIDTH % 32 != 0 || ID_W_WIDTH < 1 || ID_R_WIDTH < 1 ||
      ADDR_WIDTH < 1 || USER_REQ_W < 1 || USER_DATA_W < 1 || USER_RESP_W < 1 ||
      SID_WIDTH < 1 || SSID_WIDTH < 1 || LOOP_WIDTH < 1 || DAT_C > 128 ||
      IDW_C > 128 || IDR_C > 128 || ADR_C > 128 || UREQ_C > 128 || UDAT_C > 128 ||
      URSP_C > 128 || SID_C > 128 || SSID_C > 128) begin : g_bad
    $error("acpp_subordinate: unsupported width parameter");
  end

  // Odd parity over byte groups of a zero-extended payload; missing top bits are low.
  // Callers narrow the result by a size cast, since a call cannot be part-selected.
  function automatic logic [127:0] byte_par(input logic [1023:0] v, input int n);
    logic [127:0] r;
    r = '0;
    for (int i = 0; i < 128; i++) begin
      if (i < n) begin
        r[i] = ~^v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Handshake companions are the inversion of what this side sources.
  assign aw_ready_chk = ~aw_ready;
  assign w_ready_chk  = ~w_ready;
  assign ar_ready_chk = ~ar_ready;
  assign b_valid_chk  = ~b_valid;

  // Response checks are driven every cycle so they are correct whenever BVALID is high.
  assign b_id_chk    = IDW_C'(byte_par(1024'(b_id), IDW_C));
  assign b_resp_chk  = ~^b_resp;
  assign b_trace_chk = ~b_trace;
  assign b_loop_chk  = ~^b_loop;
  assign b_user_chk  = URSP_C'(byte_par(1024'(b_user), URSP_C));

  // Handshake mismatch, checked whenever out of reset.
  logic hs_aw;
  logic hs_w;
  logic hs_b;
  logic hs_ar;
  assign hs_aw = (aw_valid_chk == aw_valid);
  assign hs_w  = (w_valid_chk == w_valid);
  assign hs_b  = (b_ready_chk == b_ready);
  assign hs_ar = (ar_valid_chk == ar_valid);

  // Write-address payload mismatch, enabled by its VALID.
  logic pl_aw;
  assign pl_aw = aw_valid & (
      (aw_id_chk   != IDW_C'(byte_par(1024'(aw_id), IDW_C)))
    | (aw_addr_chk != ADR_C'(byte_par(1024'(aw_addr), ADR_C)))
    | (aw_len_chk  != ~^aw_len)
    | (aw_ctl0_chk != ~^aw_ctl0) | (aw_ctl1_chk != ~^aw_ctl1)
    | (aw_ctl2_chk != ~^aw_ctl2) | (aw_ctl3_chk != ~^aw_ctl3)
    | (aw_nsaid_chk != ~^aw_nsaid) | (aw_stash_nid_chk != ~^aw_stash_nid)
    | (aw_stash_lpid_chk != ~^aw_stash_lpid) | (aw_trace_chk != ~aw_trace)
    | (aw_loop_chk != ~^aw_loop) | (aw_mmu_chk != ~^aw_mmu)
    | (aw_mpam_chk != ~^aw_mpam)
    | (aw_user_chk != UREQ_C'(byte_par(1024'(aw_user), UREQ_C)))
    | (aw_sid_chk  != SID_C'(byte_par(1024'(aw_sid), SID_C)))
    | (aw_ssid_chk != SSID_C'(byte_par(1024'(aw_ssid), SSID_C))));

  // Tag groups fold in their update bit; poison groups take eight bits each.
  logic [TAG_C-1:0] tag_exp;
  logic [PSN_C-1:0] psn_exp;
  for (genvar n = 0; n < TAG_C; n++) begin : g_tag
    assign tag_exp[n] = ~^{w_tag_update[n], w_tag[4*n +: ACPP_TAG_GROUP]};
  end
  assign psn_exp = PSN_C'(byte_par(1024'(w_poison), PSN_C));

  // Write-data payload mismatch, enabled by WVALID.
  logic pl_w;
  assign pl_w = w_valid & (
      (w_data_chk   != DAT_C'(byte_par(1024'(w_data), DAT_C)))
    | (w_strb_chk   != STB_C'(byte_par(1024'(w_strb), STB_C)))
    | (w_tag_chk    != tag_exp)
    | (w_user_chk   != UDAT_C'(byte_par(1024'(w_user), UDAT_C)))
    | (w_poison_chk != psn_exp)
    | (w_last_chk   != ~w_last) | (w_trace_chk != ~w_trace));

  // Read-address payload mismatch, enabled by ARVALID.
  logic pl_ar;
  assign pl_ar = ar_valid & (
      (ar_id_chk   != IDR_C'(byte_par(1024'(ar_id), IDR_C)))
    | (ar_addr_chk != ADR_C'(byte_par(1024'(ar_addr), ADR_C)))
    | (ar_len_chk  != ~^ar_len)
    | (ar_ctl0_chk != ~^ar_ctl0) | (ar_ctl1_chk != ~^ar_ctl1));

  // Sticky flags; a new error in the clearing cycle wins. The channels are never
  // stalled or answered differently, so a fault only shows here.
  acpp_err_s ev;
  assign ev = '{ar: hs_ar | pl_ar, b: hs_b, w: hs_w | pl_w, aw: hs_aw | pl_aw};
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      err_flags <= '0;
    end else begin
      err_flags <= ev | (err_clear ? '0 : err_flags);
    end
  end

  assign err_any = |err_flags;

endmodule

`default_nettype wire

// >>> tb/acpp_subordinate_chk.sv
// Checker for the parity outputs and error flags of the subordinate block.
`timescale 1ns/1ps
`default_nettype none

module acpp_subordinate_chk
  import acpp_pkg::*;
(
  input wire logic        clk, sys_rst, aw_valid, aw_valid_chk, aw_ready, aw_ready_chk,
  input wire logic        w_valid, w_valid_chk, w_ready, w_ready_chk, ar_valid, ar_valid_chk,
  input wire logic        ar_ready, ar_ready_chk, b_valid, b_valid_chk, b_ready, b_ready_chk,
  input wire logic        b_resp_chk, b_trace, b_trace_chk, b_loop_chk, aw_len_chk,
  input wire logic        err_clear, err_any,
  input wire logic [8:0]  b_id,
  input wire logic [1:0]  b_id_chk, b_user_chk,
  input wire logic [6:0]  b_resp,
  input wire logic [7:0]  b_loop, aw_len,
  input wire logic [15:0] b_user,
  input wire acpp_err_s   err_flags
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // A clear with nothing enabled and every handshake companion consistent.
  sequence s_quiet;
    err_clear && !aw_valid && !w_valid && !ar_valid && aw_valid_chk != aw_valid
      && w_valid_chk != w_valid && ar_valid_chk != ar_valid && b_ready_chk != b_ready;
  endsequence

  // A write-address beat whose length check has even parity.
  sequence s_bad_len;
    aw_valid && aw_len_chk == ^aw_len;
  endsequence

  a_ready_inv: assert property (
    aw_ready_chk == ~aw_ready && w_ready_chk == ~w_ready && ar_ready_chk == ~ar_ready)
    else $error("ready companion not inverted");
  a_bvalid_inv: assert property (b_valid_chk == ~b_valid)
    else $error("response valid companion not inverted");
  a_bid_par: assert property (b_valid |-> b_id_chk == {~^b_id[8], ~^b_id[7:0]})
    else $error("response id check wrong");
  a_bresp_par: assert property (b_valid |-> b_resp_chk == ~^b_resp
    && b_trace_chk == ~b_trace && b_loop_chk == ~^b_loop) else $error("response check wrong");
  a_buser_par: assert property (
    b_valid |-> b_user_chk == {~^b_user[15:8], ~^b_user[7:0]}) else $error("user check wrong");
  a_aw_hs_err: assert property (aw_valid_chk == aw_valid |=> err_flags.aw)
    else $error("handshake error not flagged");
  a_len_err: assert property (s_bad_len |=> err_flags.aw && err_any)
    else $error("length error not flagged");
  a_flag_hold: assert property (!err_clear |=>
    (4'(err_flags) & 4'($past(err_flags))) == 4'($past(err_flags))) else $error("flag lost");
  a_flag_clear: assert property (s_quiet |=> 4'(err_flags) == 4'h0)
    else $error("flags not cleared");
  a_any_or: assert property (err_any == |4'(err_flags))
    else $error("summary flag wrong");
endmodule
`default_nettype wire

// >>> tb/acpp_mgr_model.sv
// Manager-side model that drives request channels with odd parity and chosen faults.
`timescale 1ns/1ps
`default_nettype none

module acpp_mgr_model (
  input  wire logic [7:0] pat,
  input  wire logic [3:0] vld,
  input  wire logic [5:0] inj,
  output logic aw_valid, aw_valid_chk, aw_len_chk, aw_ctl0_chk, aw_ctl1_chk, aw_ctl2_chk,
  output logic aw_ctl3_chk, aw_nsaid_chk, aw_stash_nid_chk, aw_stash_lpid_chk, aw_trace,
  output logic aw_trace_chk, aw_loop_chk, aw_mmu_chk, aw_mpam_chk, w_valid, w_valid_chk,
  output logic w_tag_update, w_tag_chk, w_poison_chk, w_last, w_last_chk, w_trace, w_trace_chk,
  output logic b_ready, b_ready_chk, ar_valid, ar_valid_chk, ar_len_chk, ar_ctl0_chk, ar_ctl1_chk,
  output logic [8:0]   aw_id, ar_id, aw_ctl0, ar_ctl0, aw_ctl2,
  output logic [1:0]   aw_id_chk, ar_id_chk, aw_user_chk, w_strb_chk, w_user_chk, w_poison,
  output logic [47:0]  aw_addr, ar_addr,
  output logic [5:0]   aw_addr_chk, ar_addr_chk, aw_stash_lpid,
  output logic [7:0]   aw_len, ar_len, aw_loop,
  output logic [11:0]  aw_ctl1, ar_ctl1, aw_stash_nid,
  output logic [9:0]   aw_ctl3,
  output logic [3:0]   aw_nsaid, aw_mmu, w_tag, aw_sid_chk,
  output logic [10:0]  aw_mpam,
  output logic [15:0]  aw_user, w_user, w_data_chk, w_strb,
  output logic [31:0]  aw_sid,
  output logic [19:0]  aw_ssid,
  output logic [2:0]   aw_ssid_chk,
  output logic [127:0] w_data
);
  logic [127:0] p;

  // Odd parity per byte; bits above a field's width arrive as zero.
  function automatic logic [15:0] bp(input logic [127:0] d);
    for (int i = 0; i < 16; i++) bp[i] = ~^d[8*i+:8];
  endfunction

  // One-hot fault selector: group k is corrupted while inj equals k. A decoded vector
  // rather than a function, so that every check follows a change of inj at once.
  logic [33:0] f;
  assign f = 34'h1 << inj;

  // Payloads repeat the pattern so the partial top bytes are exercised too.
  assign p = {16{pat}};
  assign {aw_id, ar_id, aw_ctl0, ar_ctl0, aw_ctl2} = {5{p[8:0]}};
  assign {aw_addr, ar_addr} = {2{p[47:0]}};
  assign {aw_len, ar_len, aw_loop} = {3{pat}};
  assign {aw_ctl1, ar_ctl1, aw_stash_nid} = {3{p[11:0]}};
  assign {aw_ctl3, aw_mpam, aw_sid, aw_ssid, w_data} = {p[9:0], p[10:0], p[31:0], p[19:0], p};
  assign {aw_nsaid, aw_mmu, w_tag, aw_stash_lpid} = {{3{pat[3:0]}}, pat[5:0]};
  assign {aw_user, w_user, w_strb} = {3{p[15:0]}};
  assign {w_poison, w_tag_update, aw_trace, w_last, w_trace} = pat[5:0];
  assign {b_ready, ar_valid, w_valid, aw_valid} = vld;

  // Handshake companions are inverted copies, driven in every cycle.
  assign aw_valid_chk = ~aw_valid ^ f[1];
  assign w_valid_chk = ~w_valid ^ f[19];
  assign b_ready_chk = ~b_ready ^ f[27];
  assign ar_valid_chk = ~ar_valid ^ f[28];

  // Request and data checks, computed whether or not the lanes are used.
  assign aw_id_chk = 2'(bp(128'(aw_id))) ^ 2'(f[2]);
  assign aw_addr_chk = 6'(bp(128'(aw_addr))) ^ 6'(f[3]);
  assign {aw_len_chk, aw_ctl0_chk, aw_ctl1_chk} = {~^aw_len ^ f[4], ~^aw_ctl0 ^ f[5],
    ~^aw_ctl1 ^ f[6]};
  assign {aw_ctl2_chk, aw_ctl3_chk} = {~^aw_ctl2 ^ f[7], ~^aw_ctl3 ^ f[8]};
  assign {aw_nsaid_chk, aw_stash_nid_chk, aw_stash_lpid_chk, aw_trace_chk} = {~^aw_nsaid ^ f[9],
    ~^aw_stash_nid ^ f[10], ~^aw_stash_lpid ^ f[11], ~aw_trace ^ f[12]};
  assign {aw_loop_chk, aw_mmu_chk, aw_mpam_chk} = {~^aw_loop ^ f[13], ~^aw_mmu ^ f[14],
    ~^aw_mpam ^ f[15]};
  assign aw_user_chk = 2'(bp(128'(aw_user))) ^ 2'(f[16]);
  assign aw_sid_chk = 4'(bp(128'(aw_sid))) ^ 4'(f[17]);
  assign aw_ssid_chk = 3'(bp(128'(aw_ssid))) ^ 3'(f[18]);
  assign w_data_chk = bp(w_data) ^ 16'(f[20]);
  assign w_strb_chk = 2'(bp(128'(w_strb))) ^ 2'(f[21]);
  assign w_tag_chk = ~^{w_tag_update, w_tag} ^ f[22];
  assign w_user_chk = 2'(bp(128'(w_user))) ^ 2'(f[23]);
  assign w_poison_chk = ~^w_poison ^ f[24];
  assign {w_last_chk, w_trace_chk} = {~w_last ^ f[25], ~w_trace ^ f[26]};
  assign ar_id_chk = 2'(bp(128'(ar_id))) ^ 2'(f[29]);
  assign ar_addr_chk = 6'(bp(128'(ar_addr))) ^ 6'(f[30]);
  assign {ar_len_chk, ar_ctl0_chk, ar_ctl1_chk} = {~^ar_len ^ f[31], ~^ar_ctl0 ^ f[32],
    ~^ar_ctl1 ^ f[33]};
endmodule
`default_nettype wire

// >>> tb/acpp_subordinate_tb.sv
// Testbench for the subordinate parity block against the manager-side model.
`timescale 1ns/1ps
`default_nettype none

module acpp_subordinate_tb
  import acpp_pkg::*;
;
  logic clk, sys_rst, err_clear, err_any, aw_ready, aw_ready_chk, w_ready, w_ready_chk, b_valid;
  logic b_valid_chk, b_resp_chk, b_trace, b_trace_chk, b_loop_chk, ar_ready, ar_ready_chk;
  logic aw_valid, aw_valid_chk, aw_len_chk, aw_ctl0_chk, aw_ctl1_chk, aw_ctl2_chk;
  logic aw_ctl3_chk, aw_nsaid_chk, aw_stash_nid_chk, aw_stash_lpid_chk, aw_trace;
  logic aw_trace_chk, aw_loop_chk, aw_mmu_chk, aw_mpam_chk, w_valid, w_valid_chk;
  logic w_tag_update, w_tag_chk, w_poison_chk, w_last, w_last_chk, w_trace, w_trace_chk;
  logic b_ready, b_ready_chk, ar_valid, ar_valid_chk, ar_len_chk, ar_ctl0_chk, ar_ctl1_chk;
  logic [8:0]   aw_id, ar_id, aw_ctl0, ar_ctl0, aw_ctl2, b_id;
  logic [1:0]   aw_id_chk, ar_id_chk, aw_user_chk, w_strb_chk, w_user_chk, w_poison, b_id_chk;
  logic [1:0]   b_user_chk;
  logic [47:0]  aw_addr, ar_addr;
  logic [5:0]   aw_addr_chk, ar_addr_chk, aw_stash_lpid, inj;
  logic [7:0]   aw_len, ar_len, aw_loop, b_loop, pat;
  logic [11:0]  aw_ctl1, ar_ctl1, aw_stash_nid;
  logic [9:0]   aw_ctl3;
  logic [3:0]   aw_nsaid, aw_mmu, w_tag, aw_sid_chk, vld;
  logic [10:0]  aw_mpam;
  logic [15:0]  aw_user, w_user, w_data_chk, w_strb, b_user;
  logic [31:0]  aw_sid;
  logic [19:0]  aw_ssid;
  logic [2:0]   aw_ssid_chk;
  logic [127:0] w_data;
  logic [6:0]   b_resp;
  acpp_err_s    err_flags;
  int           err_total = 0;
  int           checked = 0;

  acpp_subordinate i_dut (.*);
  acpp_mgr_model i_mgr (.*);

  // The subordinate core side follows the pattern so response checks see varied values.
  assign {aw_ready, w_ready, ar_ready, b_valid, b_trace} = pat[4:0];
  assign {b_id, b_resp, b_loop, b_user} = {pat[0], pat, pat[6:0], pat, pat, ~pat};

  // Free-running clock at 4 ns.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t ns: flags %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  // Correct parity over many patterns must never raise a flag.
  task automatic t_clean();
    logic [7:0] pats [6] = '{8'h00, 8'hFF, 8'hA5, 8'h3C, 8'h81, 8'h96};
    foreach (pats[i]) begin
      pat = pats[i];
      vld = 4'hF;
      step();
      step();
      chk(err_flags, 4'h0);
    end
  endtask

  // Corrupt each group in turn; payload faults count only while the valid is high.
  task automatic t_inject(input logic [3:0] v);
    logic [3:0] exp;
    for (int k = 1; k <= 33; k++) begin
      exp = k <= 18 ? 4'h1 : k <= 26 ? 4'h2 : k == 27 ? 4'h4 : 4'h8;
      if (v != 4'hF && !(k inside {1, 19, 27, 28})) exp = 4'h0;
      pat = 8'h5A;
      vld = v;
      inj = 6'(k);
      step();
      inj = 6'h00;
      chk(err_flags, exp);
      err_clear = 1'b1;
      step();
      err_clear = 1'b0;
      chk(err_flags, 4'h0);
    end
  endtask

  // A new error in the clearing cycle wins; a reset then drops a pending flag.
  // An idle edge first, so the clear strobe is not driven twice in one time step.
  task automatic t_setwin_reset();
    step();
    vld = 4'hF;
    inj = 6'd30;
    err_clear = 1'b1;
    step();
    inj = 6'd20;
    chk(err_flags, 4'h8);
    step();
    inj = 6'h00;
    chk(err_flags, 4'h2);
    err_clear = 1'b0;
    sys_rst = 1'b1;
    step();
    chk(err_flags, 4'h0);
    sys_rst = 1'b0;
    step();
    chk(err_flags, 4'h0);
  endtask

  task automatic stop_test();
    if (err_total == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence: two cycles of reset, then the scenarios.
  initial begin
    {sys_rst, err_clear, pat, vld, inj} = {1'b1, 1'b0, 8'h00, 4'h0, 6'h00};
    repeat (2) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    chk(err_flags, 4'h0);
    t_clean();
    t_inject(4'hF);
    t_inject(4'h0);
    t_setwin_reset();
    stop_test();
  end

  // Watchdog, well beyond the roughly 150 cycles the scenarios need.
  initial begin
    repeat (2000) @(posedge clk);
    err_total++;
    stop_test();
  end
endmodule

bind acpp_subordinate acpp_subordinate_chk i_chk (.*);
`default_nettype wire
